// File: rtl/ddlu_latch_core.sv
// dual converter latch logic: serial word capture, address decode and latch update
`timescale 1ns/10ps
// Overview of operation
// - transfer happens on chip select rise or seventeenth rising clock (first rise after sixteen bits), whichever first
// - address 10 loads latch A and copies buffer to latch B
// - address 00 writes data to latch B and buffer, latch A kept
// - address 01 writes buffer only, both latches kept
// - address 11 with power-down low writes reference bits to control register
// - latch B equals buffer unless last converter data write was buffer only
// - converter code is word bits 11 down to 2, bits 1..0 ignored
// - bit 14 picks fast settling when one, slow when zero
// - both latches start at zero code after reset
// - bits shift in msb first on falling clock while chip select low
// - clock edges ignored while chip select high
// - bit 13 powers down; codes kept and restored on wake
// - reference bits 00/11 external, 01 1.024V, 10 2.048V
module ddlu_latch_core #(
  parameter int WORD_WIDTH = ddlu_pkg::WORD_BITS
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic sclk_in,
  input wire logic chip_select_low_n_in,
  input wire logic data_in,
  output logic [9:0] code_a_out,
  output logic [9:0] code_b_out,
  output logic [9:0] double_buffer_out,
  output logic fast_settle_select_out,
  output logic power_down_select_out,
  output logic reference_select_high_out,
  output logic reference_select_low_out,
  output ddlu_pkg::ddlu_ref_e ref_source_out,
  output logic update_pulse_out
);
  // ===========================================================
  // elaboration check: the word layout is fixed at sixteen bits
  if (WORD_WIDTH != ddlu_pkg::WORD_BITS) begin : g_width_check
    $error("ddlu_latch_core: word width must be sixteen");
  end

  // field positions below are fixed, so a code field of another width is refused too
  if (ddlu_pkg::POS_CODE_MSB - ddlu_pkg::POS_CODE_LSB + 1 != ddlu_pkg::CODE_BITS) begin : g_code_check
    $error("ddlu_latch_core: code field must be ten bits");
  end

  // ===========================================================
  // link sampling
  // the sampler costs three clocks, so every serial clock phase must span three clocks or more
  ddlu_pkg::ddlu_link_s link;

  ddlu_link_sync u_link_sync (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .sclk_in(sclk_in),
    .chip_select_low_n_in(chip_select_low_n_in),
    .data_in(data_in),
    .link_out(link)
  );

  // ===========================================================
  // serial capture
  logic [15:0] serial_word_register_reg;
  logic [15:0] serial_word_register_next;
  logic [4:0] bit_count_reg;
  logic [4:0] bit_count_next;
  logic done_reg;
  logic done_next;
  logic transfer;

  // a pin edge reaches this decode two clocks late; latches and pulse load one clock after that
  // a word is committed once; done blocks a second commit from the late cs rise
  always_comb begin
    serial_word_register_next = serial_word_register_reg;
    bit_count_next = bit_count_reg;
    done_next = done_reg;
    transfer = 1'b0;
    if (!link.cs_active) begin
      bit_count_next = 5'h00;
      done_next = 1'b0;
      if (link.cs_rise && !done_reg && bit_count_reg == ddlu_pkg::BIT_COUNT_FULL) begin
        transfer = 1'b1;
      end
    end else begin
      if (link.sclk_fall && bit_count_reg != ddlu_pkg::BIT_COUNT_FULL) begin
        serial_word_register_next = {serial_word_register_reg[14:0], link.data};
        bit_count_next = bit_count_reg + 5'h01;
      end
      if (link.sclk_rise && !done_reg && bit_count_reg == ddlu_pkg::BIT_COUNT_FULL) begin
        transfer = 1'b1;
        done_next = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      serial_word_register_reg <= 16'h0000;
      bit_count_reg <= 5'h00;
      done_reg <= 1'b0;
    end else begin
      serial_word_register_reg <= serial_word_register_next;
      bit_count_reg <= bit_count_next;
      done_reg <= done_next;
    end
  end

  // ===========================================================
  // latch update
  // double buffer and latch B only part ways after a buffer-only write
  logic [9:0] latch_a_reg;
  logic [9:0] latch_a_next;
  logic [9:0] latch_b_reg;
  logic [9:0] latch_b_next;
  logic [9:0] buffer_reg;
  logic [9:0] buffer_next;
  logic fast_reg;
  logic fast_next;
  logic pdown_reg;
  logic pdown_next;
  logic [1:0] ref_reg;
  logic [1:0] ref_next;
  logic update_reg;
  logic update_next;
  logic [9:0] word_code;
  logic word_fast;
  logic word_pdown;
  logic [1:0] word_ref;
  ddlu_pkg::ddlu_ref_e ref_source_reg;
  ddlu_pkg::ddlu_ref_e ref_source_next;
  ddlu_pkg::ddlu_addr_e addr;

  // partial words (cs rise before sixteen bits) are dropped, not committed
  always_comb begin
    word_code = serial_word_register_reg[ddlu_pkg::POS_CODE_MSB:ddlu_pkg::POS_CODE_LSB];
    word_fast = serial_word_register_reg[ddlu_pkg::POS_FAST];
    word_pdown = serial_word_register_reg[ddlu_pkg::POS_PDOWN];
    word_ref = {serial_word_register_reg[ddlu_pkg::POS_REF_HIGH],
                serial_word_register_reg[ddlu_pkg::POS_REF_LOW]};
    addr = ddlu_pkg::ddlu_addr_e'({serial_word_register_reg[ddlu_pkg::POS_ADDR_HIGH],
                                   serial_word_register_reg[ddlu_pkg::POS_ADDR_LOW]});
    latch_a_next = latch_a_reg;
    latch_b_next = latch_b_reg;
    buffer_next = buffer_reg;
    fast_next = fast_reg;
    pdown_next = pdown_reg;
    ref_next = ref_reg;
    update_next = transfer;
    if (transfer) begin
      case (addr)
        ddlu_pkg::DDLU_ADDR_A: begin
          latch_a_next = word_code;
          latch_b_next = buffer_reg;
        end
        ddlu_pkg::DDLU_ADDR_B_BUF: begin
          latch_b_next = word_code;
          buffer_next = word_code;
        end
        ddlu_pkg::DDLU_ADDR_BUF: begin
          buffer_next = word_code;
        end
        ddlu_pkg::DDLU_ADDR_CTRL: begin
          if (!word_pdown) begin
            ref_next = word_ref;
          end
        end
        default: begin
          latch_a_next = latch_a_reg;
        end
      endcase
      // speed and power-down apply on converter data writes only
      if (addr != ddlu_pkg::DDLU_ADDR_CTRL) begin
        fast_next = word_fast;
        pdown_next = word_pdown;
      end
    end
    // reference source decoded here so the output comes straight from a register
    case (ref_next)
      2'h1: ref_source_next = ddlu_pkg::DDLU_REF_1V024;
      2'h2: ref_source_next = ddlu_pkg::DDLU_REF_2V048;
      default: ref_source_next = ddlu_pkg::DDLU_REF_EXT;
    endcase
  end

  // latches are never cleared by power-down, so wake restores the old codes
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      latch_a_reg <= ddlu_pkg::CODE_RESET;
      latch_b_reg <= ddlu_pkg::CODE_RESET;
      buffer_reg <= ddlu_pkg::CODE_RESET;
      fast_reg <= ddlu_pkg::FAST_RESET;
      pdown_reg <= ddlu_pkg::PDOWN_RESET;
      ref_reg <= ddlu_pkg::REF_RESET;
      update_reg <= 1'b0;
      ref_source_reg <= ddlu_pkg::ddlu_ref_e'(ddlu_pkg::REF_RESET);
    end else begin
      latch_a_reg <= latch_a_next;
      latch_b_reg <= latch_b_next;
      buffer_reg <= buffer_next;
      fast_reg <= fast_next;
      pdown_reg <= pdown_next;
      ref_reg <= ref_next;
      update_reg <= update_next;
      ref_source_reg <= ref_source_next;
    end
  end

  // ===========================================================
  // outputs
  always_comb begin
    code_a_out = latch_a_reg;
    code_b_out = latch_b_reg;
    double_buffer_out = buffer_reg;
    fast_settle_select_out = fast_reg;
    power_down_select_out = pdown_reg;
    reference_select_high_out = ref_reg[1];
    reference_select_low_out = ref_reg[0];
    // the pulse is registered beside the latches, so it marks the edge at which codes move
    update_pulse_out = update_reg;
    ref_source_out = ref_source_reg;
  end
endmodule

// File: pkg/ddlu_pkg.sv
// package: word layout, codes, reset values and structs for the dual converter latch logic
package ddlu_pkg;
  // ===========================================================
  // word layout
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 10;
  localparam int POS_ADDR_HIGH = 15;
  localparam int POS_FAST = 14;
  localparam int POS_PDOWN = 13;
  localparam int POS_ADDR_LOW = 12;
  localparam int POS_CODE_MSB = 11;
  localparam int POS_CODE_LSB = 2;
  localparam int POS_REF_HIGH = 1;
  localparam int POS_REF_LOW = 0;
  localparam logic [4:0] BIT_COUNT_FULL = 5'h10;
  // ===========================================================
  // reset values
  localparam logic [9:0] CODE_RESET = 10'h000;
  localparam logic [1:0] REF_RESET = 2'h0;
  localparam logic FAST_RESET = 1'b0;
  localparam logic PDOWN_RESET = 1'b0;
  // ===========================================================
  // address decode and reference source
  typedef enum logic [1:0] {
    DDLU_ADDR_B_BUF = 2'b00,
    DDLU_ADDR_BUF = 2'b01,
    DDLU_ADDR_A = 2'b10,
    DDLU_ADDR_CTRL = 2'b11
  } ddlu_addr_e;
  typedef enum logic [1:0] {
    DDLU_REF_EXT = 2'b00,
    DDLU_REF_1V024 = 2'b01,
    DDLU_REF_2V048 = 2'b10
  } ddlu_ref_e;
  // ===========================================================
  // edge events from the link sampler
  typedef struct packed {
    logic sclk_fall;
    logic sclk_rise;
    logic cs_rise;
    logic cs_active;
    logic data;
  } ddlu_link_s;
  // converter state presented to the analogue side
  typedef struct packed {
    logic [9:0] code_a;
    logic [9:0] code_b;
    logic fast_settle;
    logic power_down;
    ddlu_ref_e ref_source;
  } ddlu_dac_s;
endpackage

// File: rtl/ddlu_link_sync.sv
// link sampler: synchronises the serial pins and finds their edges
`timescale 1ns/10ps
module ddlu_link_sync (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic sclk_in,
  input wire logic chip_select_low_n_in,
  input wire logic data_in,
  output ddlu_pkg::ddlu_link_s link_out
);
  // ===========================================================
  // two-stage synchronisers plus one history stage for edges
  logic [2:0] meta_reg;
  logic [2:0] meta_next;
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic [2:0] hist_reg;
  logic [2:0] hist_next;

  // order per vector: {sclk, cs_n, data}; cs_n resets high (idle)
  always_comb begin
    meta_next = {sclk_in, chip_select_low_n_in, data_in};
    sync_next = meta_reg;
    hist_next = sync_reg;
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_reg <= 3'h2;
      sync_reg <= 3'h2;
      hist_reg <= 3'h2;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      hist_reg <= hist_next;
    end
  end

  // edge decode looks only at second and third stages
  always_comb begin
    link_out.sclk_fall = hist_reg[2] & ~sync_reg[2];
    link_out.sclk_rise = ~hist_reg[2] & sync_reg[2];
    link_out.cs_rise = ~hist_reg[1] & sync_reg[1];
    link_out.cs_active = ~sync_reg[1];
    link_out.data = sync_reg[0];
  end
endmodule

// File: test/ddlu_host_model.sv
// host serial port model: drives chip select, serial clock and data
`timescale 1ns/10ps
module ddlu_host_model (
  input wire logic clk_in,
  output logic sclk_out,
  output logic chip_select_low_n_out,
  output logic data_out
);
  // ===
  // idle pins: clock parked low, chip select released
  initial begin
    sclk_out = 1'b0;
    chip_select_low_n_out = 1'b1;
    data_out = 1'b0;
  end
  // one frame on bench clock edges; each link phase is four clocks, a 400 ns period
  // data moves with the rising link clock so it is held long past the fall
  task automatic send(input logic [15:0] w, input int nb, input bit by_sclk, input bit cs_on);
    @(posedge clk_in);
    chip_select_low_n_out <= !cs_on;
    repeat (4) @(posedge clk_in);
    for (int i = 0; i < nb; i++) begin
      data_out <= w[15 - i];
      sclk_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b0;
      repeat (4) @(posedge clk_in);
    end
    if (by_sclk) begin
      sclk_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b0;
      repeat (4) @(posedge clk_in);
    end
    chip_select_low_n_out <= 1'b1;
    data_out <= !data_out; // released line must not show the last bit
    repeat (8) @(posedge clk_in);
  endtask
endmodule

// File: test/ddlu_latch_asserts.sv
// checker: timing and decode relations at the latch core ports
`timescale 1ns/10ps
module ddlu_latch_asserts (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic chip_select_low_n_in,
  input wire logic [9:0] code_a_out,
  input wire logic [9:0] code_b_out,
  input wire logic [9:0] double_buffer_out,
  input wire logic reference_select_high_out,
  input wire logic reference_select_low_out,
  input wire logic [1:0] ref_source_out,
  input wire logic update_pulse_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // ===
  // assertions; the pulse rises at the same edge at which the codes move
  property p_pulse; update_pulse_out |=> !update_pulse_out; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse too long");
  property p_a_chg; $changed(code_a_out) |-> update_pulse_out; endproperty
  a_a_chg: assert property (p_a_chg) else $error("latch a moved without pulse");
  property p_b_chg; $changed(code_b_out) |-> code_b_out == double_buffer_out && update_pulse_out; endproperty
  a_b_chg: assert property (p_b_chg) else $error("latch b differs from buffer");
  property p_buf; $changed(double_buffer_out) |-> update_pulse_out; endproperty
  a_buf: assert property (p_buf) else $error("buffer moved without pulse");
  property p_copy; $changed(code_a_out) |-> code_b_out == double_buffer_out; endproperty
  a_copy: assert property (p_copy) else $error("buffer not copied to b");
  property p_quiet; chip_select_low_n_in [*8] |-> !update_pulse_out; endproperty
  a_quiet: assert property (p_quiet) else $error("transfer while deselected");
  property p_ctrl;
    $changed({reference_select_high_out, reference_select_low_out}) |-> $stable(code_a_out) && $stable(code_b_out);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control write moved a code");
  property p_ref;
    ref_source_out == ({reference_select_high_out, reference_select_low_out} == 2'h1 ? ddlu_pkg::DDLU_REF_1V024 :
      {reference_select_high_out, reference_select_low_out} == 2'h2 ? ddlu_pkg::DDLU_REF_2V048 : ddlu_pkg::DDLU_REF_EXT);
  endproperty
  a_ref: assert property (p_ref) else $error("reference decode wrong");
  property p_rst; $rose(reset_n_in) |-> code_a_out == 10'h000 && code_b_out == 10'h000 && double_buffer_out == 10'h000;
  endproperty
  a_rst: assert property (p_rst) else $error("codes not cleared");
  // coverage of the main transfers
  c_pulse: cover property (update_pulse_out);
  c_a: cover property ($changed(code_a_out));
  c_ref: cover property (ref_source_out == ddlu_pkg::DDLU_REF_2V048);
endmodule
bind ddlu_latch_core ddlu_latch_asserts ddlu_latch_asserts_inst (.sys_clk_in, .reset_n_in, .chip_select_low_n_in,
  .code_a_out, .code_b_out, .double_buffer_out, .reference_select_high_out, .reference_select_low_out,
  .ref_source_out, .update_pulse_out);

// File: test/testbench.sv
// testbench: host frames into the latch core, outputs checked against the word layout
`timescale 1ns/10ps
module testbench;
  typedef struct packed {
    logic [15:0] word;
    logic by_sclk;
    logic [9:0] a, b, bf;
    logic fast, pd;
    logic [1:0] rf;
  } ddlu_row_s;
  logic sys_clk_in, reset_n_in, sclk, chip_select_low_n, din, fast, pd, rhi, rlo, pulse;
  logic [9:0] code_a, code_b, dbuf;
  ddlu_pkg::ddlu_ref_e ref_src;
  int err_total = 0;
  int n_checks = 0;
  int n_pulse = 0;
  // ===
  // rows: word, end by clock, expected a, b, buffer, fast, power down, reference bits
  // the speed bit is set once by the second row and repeated by every later word
  localparam ddlu_row_s rows[10] = '{
    '{16'h0FFC, 1'h1, 10'h000, 10'h3FF, 10'h3FF, 1'h0, 1'h0, 2'h0},
    '{16'hC800, 1'h0, 10'h200, 10'h3FF, 10'h3FF, 1'h1, 1'h0, 2'h0},
    '{16'h5003, 1'h1, 10'h200, 10'h3FF, 10'h000, 1'h1, 1'h0, 2'h0},
    '{16'hC400, 1'h0, 10'h100, 10'h000, 10'h000, 1'h1, 1'h0, 2'h0},
    '{16'hD002, 1'h1, 10'h100, 10'h000, 10'h000, 1'h1, 1'h0, 2'h2},
    '{16'hD001, 1'h0, 10'h100, 10'h000, 10'h000, 1'h1, 1'h0, 2'h1},
    '{16'hD003, 1'h1, 10'h100, 10'h000, 10'h000, 1'h1, 1'h0, 2'h3},
    '{16'h6FFC, 1'h0, 10'h100, 10'h3FF, 10'h3FF, 1'h1, 1'h1, 2'h3},
    '{16'h4FFC, 1'h1, 10'h100, 10'h3FF, 10'h3FF, 1'h1, 1'h0, 2'h3},
    '{16'hC000, 1'h0, 10'h000, 10'h3FF, 10'h3FF, 1'h1, 1'h0, 2'h3}};
  ddlu_latch_core ddlu_latch_core_inst (.sys_clk_in, .reset_n_in, .sclk_in(sclk),
    .chip_select_low_n_in(chip_select_low_n), .data_in(din), .code_a_out(code_a), .code_b_out(code_b),
    .double_buffer_out(dbuf), .fast_settle_select_out(fast), .power_down_select_out(pd),
    .reference_select_high_out(rhi), .reference_select_low_out(rlo), .ref_source_out(ref_src),
    .update_pulse_out(pulse));
  ddlu_host_model ddlu_host_model_inst (.clk_in(sys_clk_in), .sclk_out(sclk),
    .chip_select_low_n_out(chip_select_low_n), .data_out(din));
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  // counted pulses tell a dropped transfer from a doubled one
  always @(posedge sys_clk_in) if (pulse === 1'b1) n_pulse++;
  task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // the model idles 8 clocks after chip select rises, past the 3 clock commit and pulse
  task automatic frame(input logic [15:0] w, input int nb, input bit by_sclk, input bit cs_on, input int np);
    int p0;
    p0 = n_pulse;
    ddlu_host_model_inst.send(w, nb, by_sclk, cs_on);
    chk("pulses", 10'(np), 10'(n_pulse - p0));
  endtask
  task automatic outs(input ddlu_row_s r);
    chk("code_a", r.a, code_a);
    chk("code_b", r.b, code_b);
    chk("buffer", r.bf, dbuf);
    chk("fast", {9'h000, r.fast}, {9'h000, fast});
    chk("pdown", {9'h000, r.pd}, {9'h000, pd});
    chk("ref", {8'h00, r.rf}, {8'h00, rhi, rlo});
    chk("ref_src", (r.rf == 2'h1 || r.rf == 2'h2) ? {8'h00, r.rf} : 10'h000, {8'h00, ref_src});
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    wrap_up;
  end
  // ===
  // main sequence
  initial begin
    reset_n_in = 1'b0;
    repeat (20) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    outs('0);
    $display("reset done");
    foreach (rows[i]) begin
      frame(rows[i].word, 16, rows[i].by_sclk, 1'b1, 1);
      outs(rows[i]);
      $display("row %0d done", i);
    end
    frame(16'h4000, 8, 1'b0, 1'b1, 0);
    outs(rows[9]);
    $display("short word done");
    frame(16'h0000, 16, 1'b1, 1'b0, 0);
    outs(rows[9]);
    $display("deselected clocks done");
    // an ignored control word still commits a transfer and strobes the pulse; only state stays put
    frame(16'hF002, 16, 1'b0, 1'b1, 1);
    outs(rows[9]);
    $display("control with power down done");
    @(posedge sys_clk_in);
    reset_n_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    outs('0);
    $display("second reset done");
    wrap_up;
  end
endmodule
